// File: logic/shadow_flow_pkg.sv
// Purpose: Shared constants for the shadow register command flow.
// Assumes: 32-bit frame words, one word per beat on the link side.
// Notes:   Offsets and field positions are used by the adapter top file and the bench.

package shadow_flow_pkg;

  // Register word offsets (byte addresses).
  localparam logic [7:0] ADDR_FEATURES  = 8'h00;
  localparam logic [7:0] ADDR_SECTORS   = 8'h04;
  localparam logic [7:0] ADDR_LBA       = 8'h08;
  localparam logic [7:0] ADDR_DEVICE    = 8'h0C;
  localparam logic [7:0] ADDR_CONTROL   = 8'h10;
  localparam logic [7:0] ADDR_COMMAND   = 8'h14;
  localparam logic [7:0] ADDR_STATUS    = 8'h18;
  localparam logic [7:0] ADDR_ERROR     = 8'h1C;
  localparam logic [7:0] ADDR_DMA_ADDR  = 8'h20;
  localparam logic [7:0] ADDR_DMA_CTRL  = 8'h24;
  localparam logic [7:0] ADDR_INT_STAT  = 8'h28;
  localparam logic [7:0] ADDR_INT_MASK  = 8'h2C;
  localparam logic [7:0] ADDR_DMA_COUNT = 8'h30;

  // Field positions.
  localparam int BUSY_BIT      = 7;
  localparam int DMA_RUN_BIT   = 0;
  localparam int DMA_DIR_BIT   = 1;
  localparam int DMA_ABORT_BIT = 2;
  localparam int FIS_INT_BIT   = 14;

  // Interrupt status bits.
  localparam int EV_DONE       = 0;
  localparam int EV_NODATA     = 1;
  localparam int EV_DATA       = 2;
  localparam int EV_WIDTH      = 3;

  // Frame type codes and lengths.
  localparam logic [7:0] FIS_REG_H2D = 8'h27;
  localparam logic [7:0] FIS_REG_D2H = 8'h34;
  localparam logic [7:0] FIS_DATA    = 8'h46;
  localparam logic [2:0] REG_FIS_WORDS = 3'h5;

  // Reset values.
  localparam logic [7:0]  STATUS_RESET = 8'h50;
  localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;

endpackage : shadow_flow_pkg

// File: logic/frame_if.sv
// Purpose: Word stream with framing between the bridge and its sub-blocks.
// Assumes: One word per cycle while valid and ready are both high.
// Notes:   Last marks the final word of a frame.

`timescale 1ns/1ps

interface frame_if;
  logic        valid;
  logic        ready;
  logic        last;
  logic [31:0] data;

  modport src
  (
    output valid,
    output last,
    output data,
    input  ready
  );

  modport dst
  (
    input  valid,
    input  last,
    input  data,
    output ready
  );
endinterface : frame_if

// File: logic/reg_frame_tx.sv
// Purpose: Serialises a host-to-drive register frame from shadow contents.
// Assumes: Snapshot is taken on the start pulse and held until sent.
// Notes:   Five words, type code in the low byte of word zero.

`timescale 1ns/1ps

module reg_frame_tx
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_start,
  input  wire logic [31:0] i_words [5],
  frame_if.src             tx
);
  import shadow_flow_pkg::*;

  typedef struct packed {
    logic        active;
    logic [2:0]  idx;
    logic [159:0] snap;
  } tx_state_t;

  tx_state_t s_q;
  tx_state_t s_d;

  // Snapshot on start so later host writes cannot corrupt the frame.
  always_comb
  begin
    s_d = s_q;
    if (i_start && !s_q.active)
    begin
      s_d.active = 1'b1;
      s_d.idx    = 3'h0;
      s_d.snap   = {i_words[4], i_words[3], i_words[2], i_words[1],
                    i_words[0]};
    end
    else if (s_q.active && tx.ready)
    begin
      // Wrap to word zero so idle data never indexes past the snapshot.
      if (s_q.idx == REG_FIS_WORDS - 3'h1)
      begin
        s_d.active = 1'b0;
        s_d.idx    = 3'h0;
      end
      else
        s_d.idx = s_q.idx + 3'h1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tx.valid = s_q.active;
  assign tx.last  = (s_q.idx == REG_FIS_WORDS - 3'h1);
  assign tx.data  = s_q.snap[32*s_q.idx +: 32];

endmodule : reg_frame_tx

// File: logic/dma_writer.sv
// Purpose: Armed DMA engine that writes received data words to memory.
// Assumes: Memory port accepts one word per cycle when ready.
// Notes:   Words arriving while not armed are drained and dropped.

`timescale 1ns/1ps

module dma_writer
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_load,
  input  wire logic [31:0] i_base,
  input  wire logic        i_armed,
  input  wire logic        i_mem_ready,
  frame_if.dst             rx,
  output logic             o_mem_we,
  output logic [31:0]      o_mem_addr,
  output logic [31:0]      o_mem_data,
  output logic [31:0]      o_count
);
  import shadow_flow_pkg::*;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] count;
  } dma_state_t;

  dma_state_t s_q;
  dma_state_t s_d;
  logic       take;

  // Back-pressure reaches the link while armed and memory is busy.
  assign rx.ready = i_armed ? i_mem_ready : 1'b1;
  assign take     = rx.valid && i_armed && i_mem_ready;

  // Pointer advances one word per accepted beat.
  always_comb
  begin
    s_d = s_q;
    if (i_load)
    begin
      s_d.addr  = i_base;
      s_d.count = ZERO_WORD;
    end
    else if (take)
    begin
      s_d.addr  = s_q.addr + 32'h0000_0004;
      s_d.count = s_q.count + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign o_mem_we   = take;
  assign o_mem_addr = s_q.addr;
  assign o_mem_data = rx.data;
  assign o_count    = s_q.count;

endmodule : dma_writer

// File: logic/shadow_cmd_dma_read_flow.sv
// Purpose: Host adapter bridge between shadow task-file registers and link.
// Assumes: Link frames arrive as 32-bit words with a last marker.
// Notes:   Registers reached over a plain strobe port; one clock domain.
//
// Added by the designer: strobed register access and the register offsets.

`timescale 1ns/1ps

module shadow_cmd_dma_read_flow
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  output logic             o_irq,
  input  wire logic        i_rx_valid,
  input  wire logic        i_rx_last,
  input  wire logic [31:0] i_rx_data,
  output logic             o_rx_ready,
  output logic             o_tx_valid,
  output logic             o_tx_last,
  output logic [31:0]      o_tx_data,
  input  wire logic        i_tx_ready,
  output logic             o_mem_we,
  output logic [31:0]      o_mem_addr,
  output logic [31:0]      o_mem_data,
  input  wire logic        i_mem_ready
);
  import shadow_flow_pkg::*;

  typedef enum logic [1:0] {ST_HDR, ST_DATA, ST_REG, ST_DROP} rx_phase_t;

  typedef struct packed {
    logic [7:0]  features;
    logic [15:0] sectors;
    logic [31:0] lba;
    logic [7:0]  device;
    logic [7:0]  control;
    logic [7:0]  command;
    logic [7:0]  status;
    logic [7:0]  error;
    logic [31:0] dma_base;
    logic [2:0]  dma_ctrl;
    logic        data_seen;
    logic [EV_WIDTH-1:0] int_stat;
    logic [EV_WIDTH-1:0] int_mask;
    rx_phase_t   phase;
    logic [2:0]  widx;
    logic        end_int;
    logic        send;
    logic        load;
    logic [31:0] rdata;
    logic        irq;
    logic        rx_ready;
    logic        tx_valid;
    logic        tx_last;
    logic [31:0] tx_data;
    logic        mem_we;
    logic [31:0] mem_addr;
    logic [31:0] mem_data;
  } top_state_t;

  top_state_t   s_q;
  top_state_t   s_d;
  logic [31:0]  words [5];
  logic [31:0]  dma_count;
  logic         dma_we;
  logic [31:0]  dma_addr;
  logic         rx_take;
  logic         dma_sel;
  logic         end_hdr;
  logic         end_word;

  // Internal word streams from the sender and towards the DMA engine.
  frame_if tx_bus ();
  frame_if dma_bus ();

  // Register decode used by the write path; reads decode with a case.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // Frame type sits in the low byte of the header word.
  function automatic logic is_kind(input logic [31:0] w,
                                   input logic [7:0]  code);
    is_kind = (w[7:0] == code);
  endfunction : is_kind

  // Shadow contents laid out as a host-to-drive register frame.
  assign words[0] = {s_q.features, s_q.command, 8'h80, FIS_REG_H2D};
  assign words[1] = {s_q.device, s_q.lba[23:0]};
  assign words[2] = {s_q.features, s_q.lba[31:24], 16'h0000};
  assign words[3] = {s_q.control, 8'h00, s_q.sectors};
  assign words[4] = ZERO_WORD;

  reg_frame_tx u_tx
  (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_start    (s_q.send),
    .i_words    (words),
    .tx         (tx_bus.src)
  );

  // Data beats reach the engine only while a data frame is open, and only
  // when the link really takes them, so no word is written twice.
  assign dma_sel       = (s_q.phase == ST_DATA);
  assign dma_bus.valid = rx_take && dma_sel;
  assign dma_bus.last  = i_rx_last;
  assign dma_bus.data  = i_rx_data;
  assign rx_take       = i_rx_valid && s_q.rx_ready;

  // An ending frame closes on its last word, which may be the header itself.
  assign end_hdr  = (s_q.phase == ST_HDR) && is_kind(i_rx_data, FIS_REG_D2H);
  assign end_word = rx_take && i_rx_last && (s_q.phase == ST_REG || end_hdr);

  dma_writer u_dma
  (
    .i_core_clk  (i_core_clk),
    .i_rst_n     (i_rst_n),
    .i_load      (s_q.load),
    .i_base      (s_q.dma_base),
    .i_armed     (s_q.dma_ctrl[DMA_RUN_BIT]),
    .i_mem_ready (i_mem_ready),
    .rx          (dma_bus.dst),
    .o_mem_we    (dma_we),
    .o_mem_addr  (dma_addr),
    .o_mem_data  (),
    .o_count     (dma_count)
  );

  // A word leaves only while its registered copy is shown, so the drive
  // counts it once; the cost is an idle cycle between words.
  assign tx_bus.ready = i_tx_ready && s_q.tx_valid;

  // Next-state logic for registers, frame receiver and outputs.
  always_comb
  begin
    s_d          = s_q;
    // Strobes and the read answer last a single cycle.
    s_d.send     = 1'b0;
    s_d.load     = 1'b0;
    s_d.rdata    = ZERO_WORD;

    // Host register writes.
    if (i_wr)
    begin
      if (hit(i_addr, ADDR_FEATURES))  s_d.features = i_wdata[7:0];
      if (hit(i_addr, ADDR_SECTORS))   s_d.sectors  = i_wdata[15:0];
      if (hit(i_addr, ADDR_LBA))       s_d.lba      = i_wdata;
      if (hit(i_addr, ADDR_DEVICE))    s_d.device   = i_wdata[7:0];
      if (hit(i_addr, ADDR_CONTROL))   s_d.control  = i_wdata[7:0];
      if (hit(i_addr, ADDR_DMA_ADDR))  s_d.dma_base = i_wdata;
      if (hit(i_addr, ADDR_INT_MASK))
        s_d.int_mask = i_wdata[EV_WIDTH-1:0];
      if (hit(i_addr, ADDR_INT_STAT))
        s_d.int_stat = s_q.int_stat & ~i_wdata[EV_WIDTH-1:0];
      if (hit(i_addr, ADDR_DMA_CTRL))
      begin
        // Abort tears the engine down; run flag arms it with a fresh base.
        s_d.dma_ctrl = i_wdata[DMA_ABORT_BIT] ? 3'h0 : i_wdata[2:0];
        s_d.load     = i_wdata[DMA_RUN_BIT] && !i_wdata[DMA_ABORT_BIT];
      end
      // Command goes last; it marks busy and launches the frame.
      if (hit(i_addr, ADDR_COMMAND))
      begin
        s_d.command          = i_wdata[7:0];
        s_d.status[BUSY_BIT] = 1'b1;
        s_d.send             = 1'b1;
        s_d.data_seen        = 1'b0;
      end
    end

    // Host register reads, answered in the next cycle.
    if (i_rd)
    begin
      case (i_addr)
        ADDR_FEATURES:  s_d.rdata = {24'h000000, s_q.features};
        ADDR_SECTORS:   s_d.rdata = {16'h0000, s_q.sectors};
        ADDR_LBA:       s_d.rdata = s_q.lba;
        ADDR_DEVICE:    s_d.rdata = {24'h000000, s_q.device};
        ADDR_CONTROL:   s_d.rdata = {24'h000000, s_q.control};
        ADDR_COMMAND:   s_d.rdata = {24'h000000, s_q.command};
        ADDR_STATUS:    s_d.rdata = {24'h000000, s_q.status};
        ADDR_ERROR:     s_d.rdata = {24'h000000, s_q.error};
        ADDR_DMA_ADDR:  s_d.rdata = dma_addr;
        ADDR_DMA_CTRL:  s_d.rdata = {29'h0, s_q.dma_ctrl};
        ADDR_INT_STAT:  s_d.rdata = {29'h0, s_q.int_stat};
        ADDR_INT_MASK:  s_d.rdata = {29'h0, s_q.int_mask};
        ADDR_DMA_COUNT: s_d.rdata = dma_count;
        default:        s_d.rdata = ZERO_WORD;
      endcase
    end

    // Frame receiver; the header word picks the destination.
    if (rx_take)
    begin
      case (s_q.phase)
        ST_HDR:
        begin
          // Header word; a one-word frame also closes here.
          if (is_kind(i_rx_data, FIS_DATA))
          begin
            // Unarmed data is drained so the link never hangs.
            s_d.phase     = s_q.dma_ctrl[DMA_RUN_BIT] ? ST_DATA : ST_DROP;
            s_d.data_seen = 1'b1;
          end
          else if (is_kind(i_rx_data, FIS_REG_D2H))
          begin
            s_d.phase   = ST_REG;
            s_d.end_int = i_rx_data[FIS_INT_BIT];
            s_d.status  = i_rx_data[23:16];
            s_d.error   = i_rx_data[31:24];
            s_d.widx    = 3'h1;
          end
          else
            s_d.phase = ST_DROP;
          if (i_rx_last)
            s_d.phase = ST_HDR;
        end
        ST_REG:
        begin
          // Later words refresh the device, LBA and sector count registers.
          case (s_q.widx)
            3'h1:    {s_d.device, s_d.lba[23:0]} = i_rx_data;
            3'h2:    s_d.lba[31:24] = i_rx_data[7:0];
            3'h3:    s_d.sectors = i_rx_data[15:0];
            default: s_d.widx = s_q.widx;
          endcase
          s_d.widx = s_q.widx + 3'h1;
        end
        // Payload words pass by; the engine takes them in ST_DATA, ST_DROP drops them.
        ST_DATA:  s_d.phase = s_q.phase;
        ST_DROP:  s_d.phase = s_q.phase;
        default:  s_d.phase = ST_HDR;
      endcase
      if (i_rx_last && s_q.phase != ST_HDR)
        s_d.phase = ST_HDR;
      // Ending frame complete: raise events, set wins over clear.
      // Done follows the frame's own flag; no data seen raises the no-data event.
      if (end_word)
      begin
        if (s_q.phase == ST_REG ? s_q.end_int : i_rx_data[FIS_INT_BIT])
          s_d.int_stat[EV_DONE] = 1'b1;
        if (!s_q.data_seen)
          s_d.int_stat[EV_NODATA] = 1'b1;
      end
      // A closed data frame tells software that payload has landed.
      if (s_q.phase == ST_DATA && i_rx_last)
        s_d.int_stat[EV_DATA] = 1'b1;
    end

    // Receive ready follows the engine in a data frame.
    s_d.rx_ready = (s_d.phase == ST_DATA) ? dma_bus.ready : 1'b1;
    // Level interrupt from the next state, so the pin is a flip-flop.
    s_d.irq      = |(s_d.int_stat & s_d.int_mask);
    // Registered copies of the sender and engine outputs.
    s_d.tx_valid = tx_bus.valid && !(s_q.tx_valid && i_tx_ready);
    s_d.tx_last  = tx_bus.last;
    s_d.tx_data  = tx_bus.data;
    s_d.mem_we   = dma_we;
    s_d.mem_addr = dma_addr;
    s_d.mem_data = i_rx_data;
  end

  // One register stage holds every output and all state outside the sender and engine.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s_q        <= '0;
      s_q.status <= STATUS_RESET;
      s_q.phase  <= ST_HDR;
    end
    else
      s_q <= s_d;
  end

  // Every output is a bit of the state register.
  assign o_rdata    = s_q.rdata;
  assign o_irq      = s_q.irq;
  assign o_rx_ready = s_q.rx_ready;
  assign o_tx_valid = s_q.tx_valid;
  assign o_tx_last  = s_q.tx_last;
  assign o_tx_data  = s_q.tx_data;
  assign o_mem_we   = s_q.mem_we;
  assign o_mem_addr = s_q.mem_addr;
  assign o_mem_data = s_q.mem_data;

endmodule : shadow_cmd_dma_read_flow

// File: tb/drive_model.sv
// Purpose: Behavioural drive on the far side of the link.
// Assumes: One word moves per valid and ready handshake.
// Notes:   Released data lines show the inverse of the last word.
`timescale 1ns/1ps
module drive_model
(
  input  wire logic        i_core_clk,
  input  wire logic        i_tx_valid,
  input  wire logic        i_tx_last,
  input  wire logic [31:0] i_tx_data,
  output logic             o_tx_ready,
  output logic             o_rx_valid,
  output logic             o_rx_last,
  output logic [31:0]      o_rx_data,
  input  wire logic        i_rx_ready
);
  logic       slow = 1'b0;
  int         frames = 0;
  int         len = 0;
  int         cnt = 0;
  logic [7:0] kind;
  logic [31:0] w0;
  logic [31:0] w1;

  initial {o_tx_ready, o_rx_valid, o_rx_last, o_rx_data} = '0;

  // Takes host frames; a slow drive is ready only every other cycle.
  always @(posedge i_core_clk)
  begin
    o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
    if (i_tx_valid && o_tx_ready)
    begin
      if (cnt == 0)
        kind = i_tx_data[7:0];
      if (cnt == 0)
        w0 = i_tx_data;
      if (cnt == 1)
        w1 = i_tx_data;
      cnt = cnt + 1;
      if (i_tx_last)
      begin
        len = cnt;
        frames++;
        cnt = 0;
      end
    end
  end

  // Sends header plus n words, each held until the adapter takes it.
  task automatic send(input logic [31:0] head, input int n);
    for (int i = 0; i <= n; i++)
    begin
      o_rx_valid <= 1'b1;
      o_rx_last  <= (i == n);
      o_rx_data  <= (i == 0) ? head : 32'hA500_0000 + i;
      @(posedge i_core_clk);
      while (!i_rx_ready)
        @(posedge i_core_clk);
    end
    o_rx_valid <= 1'b0;
    o_rx_last  <= 1'b0;
    o_rx_data  <= ~o_rx_data;
  endtask : send
endmodule : drive_model

// File: tb/shadow_cmd_dma_read_flow_chk.sv
// Purpose: Port assertions for the shadow register command flow.
// Assumes: One clock domain, active-low asynchronous reset.
// Notes:   Bound to the adapter from the bench top file.
`timescale 1ns/1ps
module shadow_cmd_dma_read_flow_chk
  import shadow_flow_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        o_irq,
  input wire logic        i_rx_valid,
  input wire logic        i_rx_last,
  input wire logic        o_rx_ready,
  input wire logic        o_tx_valid,
  input wire logic        o_tx_last,
  input wire logic [31:0] o_tx_data,
  input wire logic        i_tx_ready,
  input wire logic        o_mem_we,
  input wire logic [31:0] o_mem_addr,
  input wire logic        i_mem_ready
);
  typedef struct packed {
    logic [2:0] words;
    logic [2:0] age;
  } watch_t;
  watch_t st_q;
  watch_t st_d;
  logic   ev;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  // Age saturates so a stale interrupt cause never looks fresh.
  assign ev = (i_rx_valid && o_rx_ready && i_rx_last) ||
              (i_wr && i_addr == ADDR_INT_MASK);

  // Counts words of the outgoing frame and cycles since an irq cause.
  always_comb
  begin
    st_d = st_q;
    if (o_tx_valid && i_tx_ready)
      st_d.words = o_tx_last ? 3'h0 : st_q.words + 3'h1;
    st_d.age = ev ? 3'h0 : (st_q.age == 3'h7 ? 3'h7 : st_q.age + 3'h1);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
    if (!i_rst_n)
      st_q <= {3'h0, 3'h7};
    else
      st_q <= st_d;

  sequence cmd_wr;
    i_wr && i_addr == ADDR_COMMAND;
  endsequence
  sequence mem_beat;
    o_mem_we && i_mem_ready;
  endsequence
  sequence stat_clr;
    (i_wr && i_addr == ADDR_INT_STAT && i_wdata[2:0] == 3'h7
      && !i_rx_valid) ##1 !i_rx_valid [*2];
  endsequence

  tx_start_a: assert property (cmd_wr |-> ##[1:8] o_tx_valid)
    else $error("no frame after command write");
  tx_type_a: assert property ($rose(o_tx_valid) && st_q.words == 3'h0
    |-> o_tx_data[7:0] == FIS_REG_H2D) else $error("bad frame type");
  tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=>
    o_tx_valid && $stable(o_tx_data)) else $error("tx word dropped");
  tx_len_a: assert property (o_tx_valid && i_tx_ready && o_tx_last
    |-> st_q.words == 3'h4) else $error("tx frame not five words");
  mem_step_a: assert property (mem_beat ##1 mem_beat |->
    o_mem_addr == $past(o_mem_addr) + 32'h4) else $error("dma step");
  irq_cause_a: assert property ($rose(o_irq) |->
    st_q.age <= 3'h4) else $error("irq without cause");
  irq_clear_a: assert property (stat_clr |-> !o_irq)
    else $error("irq stays after clear");
  mask_off_a: assert property (i_wr && i_addr == ADDR_INT_MASK
    && i_wdata[2:0] == 3'h0 |-> ##2 !o_irq) else $error("mask ignored");
endmodule : shadow_cmd_dma_read_flow_chk

// File: tb/shadow_cmd_dma_read_flow_tb.sv
// Purpose: Self-checking bench for the shadow register command flow.
// Assumes: The drive model stands on the link side of the adapter.
// Notes:   Each register access takes two core clock cycles.
`timescale 1ns/1ps
module shadow_cmd_dma_read_flow_tb;
  import shadow_flow_pkg::*;
  logic        i_core_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_mem_ready = 1'b1;
  logic [31:0] o_rdata, o_tx_data, o_mem_addr, o_mem_data, i_rx_data, v;
  logic        o_irq, i_rx_valid, i_rx_last, o_rx_ready, i_tx_ready;
  logic        o_tx_valid, o_tx_last, o_mem_we;
  int          n_errors = 0;
  int          n_checks = 0;
  int          n_mem = 0;

  always #50 i_core_clk = ~i_core_clk;

  shadow_cmd_dma_read_flow u_shadow_cmd_dma_read_flow
  (
    .i_core_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .o_irq, .i_rx_valid, .i_rx_last, .i_rx_data, .o_rx_ready, .o_tx_valid,
    .o_tx_last, .o_tx_data, .i_tx_ready, .o_mem_we, .o_mem_addr,
    .o_mem_data, .i_mem_ready
  );

  drive_model u_drive_model
  (
    .i_core_clk, .i_tx_valid(o_tx_valid), .i_tx_last(o_tx_last),
    .i_tx_data(o_tx_data), .o_tx_ready(i_tx_ready),
    .o_rx_valid(i_rx_valid), .o_rx_last(i_rx_last),
    .o_rx_data(i_rx_data), .i_rx_ready(o_rx_ready)
  );

  task automatic chk(input string n, input logic [31:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      $display("mismatch %s exp %h got %h", n, e, g);
      n_errors++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    @(posedge i_core_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    @(posedge i_core_clk);
    d = o_rdata;
  endtask : rd

  // Loads the shadow groups, command last, then waits for the frame.
  task automatic cmd(input logic [7:0] c);
    int t;
    wr(ADDR_FEATURES, 32'h0);
    wr(ADDR_SECTORS, 32'h4);
    wr(ADDR_LBA, 32'h0012_3456);
    t = u_drive_model.frames;
    wr(ADDR_COMMAND, {24'h0, c});
    rd(ADDR_STATUS, v);
    chk("busy", 1'b1, v[BUSY_BIT]);
    for (int i = 0; i < 60 && u_drive_model.frames == t; i++)
      @(posedge i_core_clk);
    chk("tx_len", 32'd5, u_drive_model.len);
    chk("tx_type", FIS_REG_H2D, u_drive_model.kind);
    chk("tx_frame", t + 1, u_drive_model.frames);
    chk("tx_cmd", c, u_drive_model.w0[23:16]);
    chk("tx_lba", 32'h0012_3456, {8'h00, u_drive_model.w1[23:0]});
  endtask : cmd

  // Sends the ending frame and polls until busy drops.
  task automatic fin(input logic [7:0] s, e, input logic f);
    u_drive_model.send({e, s, 1'b0, f, 6'h0, FIS_REG_D2H}, 4);
    for (int i = 0; i < 10; i++)
    begin
      rd(ADDR_STATUS, v);
      if (v[BUSY_BIT] === 1'b0)
        break;
    end
    chk("status", s, v[7:0]);
  endtask : fin

  task automatic results;
    if (n_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  // Memory writes must walk up from the base in payload order.
  always @(posedge i_core_clk)
    if (o_mem_we && i_mem_ready)
    begin
      chk("mem_addr", 32'h1000 + 4 * n_mem, o_mem_addr);
      chk("mem_data", 32'hA500_0001 + n_mem, o_mem_data);
      n_mem++;
    end

  initial
  begin
    repeat (5) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    rd(ADDR_STATUS, v);
    chk("status_rst", STATUS_RESET, v[7:0]);
    rd(8'h3C, v);
    chk("unmapped", 32'h0, v);
    wr(ADDR_INT_MASK, 32'h7);
    wr(ADDR_DMA_ADDR, 32'h0000_1000);
    wr(ADDR_DMA_CTRL, 32'h1);
    cmd(8'hC8);
    u_drive_model.send({24'h0, FIS_DATA}, 4);
    rd(ADDR_STATUS, v);
    chk("busy_hold", 1'b1, v[BUSY_BIT]);
    fin(8'h50, 8'h00, 1'b1);
    chk("mem_words", 32'd4, n_mem);
    rd(ADDR_INT_STAT, v);
    chk("int_stat", 32'h5, v);
    chk("irq_on", 1'b1, o_irq);
    wr(ADDR_INT_MASK, 32'h0);
    rd(ADDR_INT_STAT, v);
    chk("irq_masked", 1'b0, o_irq);
    wr(ADDR_INT_MASK, 32'h7);
    wr(ADDR_INT_STAT, 32'h7);
    rd(ADDR_INT_STAT, v);
    chk("int_clear", 32'h0, v);
    chk("irq_off", 1'b0, o_irq);
    // Slow drive, no data frame, error status and no interrupt flag.
    u_drive_model.slow = 1'b1;
    cmd(8'hC8);
    fin(8'h51, 8'h04, 1'b0);
    rd(ADDR_ERROR, v);
    chk("error", 32'h4, v[7:0]);
    rd(ADDR_INT_STAT, v);
    chk("int_nodata", 32'h2, v);
    wr(ADDR_DMA_CTRL, 32'h4);
    wr(ADDR_DMA_CTRL, 32'h0);
    u_drive_model.send({24'h0, FIS_DATA}, 2);
    rd(ADDR_INT_STAT, v);
    chk("mem_unarmed", 32'd4, n_mem);
    results();
  end

  // Cuts a hang short well past the hundred or so cycles the tests need.
  initial
  begin
    repeat (5000) @(posedge i_core_clk);
    n_errors++;
    results();
  end
endmodule : shadow_cmd_dma_read_flow_tb

bind shadow_cmd_dma_read_flow shadow_cmd_dma_read_flow_chk u_chk
(
  .i_core_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .o_irq, .i_rx_valid,
  .i_rx_last, .o_rx_ready, .o_tx_valid, .o_tx_last, .o_tx_data,
  .i_tx_ready, .o_mem_we, .o_mem_addr, .i_mem_ready
);
